// >>> hw/keying_pkg.sv
// Register map, field layout, limits and enumerations of the keying block.
package keying_pkg;

  // Register byte offsets.
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_RATE [3] = '{8'h04, 8'h08, 8'h0c};
  localparam logic [7:0] OFS_CAR_PHASE = 8'h10;
  localparam logic [7:0] OFS_MOD_PHASE = 8'h14;
  localparam logic [7:0] OFS_SHAPES = 8'h18;
  localparam logic [7:0] OFS_PWM_NOM = 8'h1c;
  localparam logic [7:0] OFS_PWM_DEV = 8'h20;
  localparam logic [7:0] OFS_PWM_EDGE = 8'h24;
  localparam logic [7:0] OFS_SUM_RATIO = 8'h28;
  localparam logic [7:0] OFS_CAR_AMPL = 8'h2c;
  localparam logic [7:0] OFS_STATUS = 8'h30;

  // Control register fields.
  localparam int CTRL_TYPE_LSB = 0;
  localparam int CTRL_MOD_EN = 3;
  localparam int CTRL_EXT = 4;
  localparam int CTRL_REAR = 5;
  localparam int CTRL_FSK_NEG = 6;
  localparam int CTRL_PSK_NEG = 7;
  localparam int CTRL_BY_DUTY = 8;
  localparam int CTRL_SHAPE_LSB = 12;
  localparam int SHAPES_SUM_LSB = 4;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

  typedef enum logic [1:0] {
    MOD_FSK = 2'b00,
    MOD_PSK = 2'b01,
    MOD_PWM = 2'b10,
    MOD_SUM = 2'b11
  } mod_type_t;

  typedef enum logic [2:0] {
    CAR_SINE = 3'b000,
    CAR_SQUARE = 3'b001,
    CAR_RAMP = 3'b010,
    CAR_PULSE = 3'b011,
    CAR_NOISE = 3'b100,
    CAR_ARB = 3'b101,
    CAR_DC = 3'b110
  } carrier_t;

  typedef enum logic [2:0] {
    SHP_SINE = 3'b000,
    SHP_SQUARE = 3'b001,
    SHP_TRIANGLE = 3'b010,
    SHP_RISING_SAWTOOTH = 3'b011,
    SHP_FALLING_SAWTOOTH = 3'b100,
    SHP_NOISE = 3'b101,
    SHP_ARB = 3'b110
  } mod_shape_t;

  // Rates in mHz, phases in 0.01 degree, duty in 0.01 percent.
  localparam logic [29:0] RATE_MIN = 30'd2;
  localparam logic [29:0] RATE_MAX = 30'd1_000_000_000;
  localparam logic [29:0] RATE_RESET = 30'd100_000;
  localparam int PHASE_LIMIT = 36000;
  localparam logic [16:0] CAR_PHASE_RESET = 17'h0_0000;
  localparam logic [15:0] MOD_PHASE_RESET = 16'd18000;
  localparam logic [31:0] DUTY_DEV_MAX = 32'd4999;
  localparam logic [31:0] DUTY_FULL = 32'd10000;
  localparam logic [6:0] RATIO_RESET = 7'd50;
  localparam logic [6:0] RATIO_MAX = 7'd100;
  localparam logic [7:0] PCT_FULL = 8'd100;
  localparam logic [39:0] MAX_PEAK = 40'd10000;

  // Accumulator increment per mHz of rate at the system clock.
  localparam longint CLK_HZ = 125_000_000;
  localparam longint MHZ_PER_HZ = 1000;
  localparam int ACC_W = 48;
  localparam logic [11:0] INC_SCALE =
    12'((64'd1 << ACC_W) / (CLK_HZ * MHZ_PER_HZ));

  localparam logic signed [11:0] MOD_FULL = 12'sh7ff;
  localparam logic [15:0] LFSR_TAPS = 16'hb400;
  localparam logic [15:0] LFSR_SEED = 16'hace1;

endpackage

// >>> hw/keying_pulse_sum_modulator.sv
// Keying, pulse width and summing modulation control with an APB slave.
//
// Operation
// RQ1: Positive FSK: low carrier, high alternate.
// RQ2: Negative FSK: low alternate, high carrier.
// RQ3: Carrier phase -360..360 degrees, resets zero.
// RQ4: Internal keying uses a 50% square.
// RQ5: Port select picks front or rear input.
// RQ6: Keying rate 2 mHz..1 MHz, default 100 Hz.
// RQ7: External source disables the internal keying rate.
// RQ8: Modulation phase 0..360 degrees, default 180.
// RQ9: PSK polarity picks carrier or modulation phase.
// RQ10: Pulse carrier with modulation forces PWM.
// RQ11: PWM internal shape from seven choices.
// RQ12: External level sets deviation linearly, full scale.
// RQ13: PWM frequency 2 mHz..1 MHz, default 100 Hz.
// RQ14: Deviation unit follows width or duty setting.
// RQ15: Width swings nominal plus/minus limited deviation.
// RQ16: Duty deviation capped at 49.99 percent.
// RQ17: Summing adds chosen shape at chosen frequency.
// RQ18: Sum amplitude is carrier times one plus ratio.
// RQ19: PSK carrier limited to sine, square, ramp, arb.
// RQ20: Switching applies next sample, phase not reset.
//
// Added by the designer: the APB register port and the register addresses.
`timescale 1ns/100ps

module keying_pulse_sum_modulator (
  // Clock, reset and clock enable.
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // APB slave.
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Modulation sources.
  input wire logic front_key_in,
  input wire logic rear_key_in,
  input wire logic signed [11:0] front_level,
  input wire logic signed [11:0] arb_sample,
  // Modulation results toward the waveform engine.
  output logic freq_alt,
  output logic signed [16:0] phase_out,
  output logic [31:0] pwm_width,
  output logic [39:0] sum_ampl,
  output logic signed [11:0] sum_wave,
  output logic key_level
);

  // Software state.
  logic [31:0] ctrl;
  logic [29:0] rate [3];
  logic signed [16:0] car_phase;
  logic [15:0] mod_phase;
  logic [7:0] shapes;
  logic [31:0] pwm_nom;
  logic [31:0] pwm_dev;
  logic [31:0] pwm_edge;
  logic [6:0] sum_ratio;
  logic [31:0] car_ampl;

  // Source and generator state.
  logic front_s1, front_s2, rear_s1, rear_s2;
  logic [keying_pkg::ACC_W-1:0] acc [3];
  logic [15:0] lfsr;

  logic bus_access, wr_en;
  logic ext_src, use_rear, mod_en, fsk_neg, psk_neg, by_duty;
  keying_pkg::mod_type_t eff_type;
  keying_pkg::carrier_t car_shape;
  logic psk_carrier_ok, key_now;
  logic [2:0] acc_run;
  logic signed [11:0] pwm_mod, sum_mod;
  logic [31:0] dev_lim, dev_eff, nom_less_edge, full_less;
  logic signed [44:0] dev_prod;
  logic signed [33:0] width_sum;
  logic [39:0] ampl_prod;

  // Clamps a written rate into the legal span.
  function automatic logic [29:0] clamp_rate(input logic [31:0] v);
    logic [29:0] r;
    r = keying_pkg::RATE_MIN;
    if (v >= 32'(keying_pkg::RATE_MAX)) begin
      r = keying_pkg::RATE_MAX;
    end else if (v > 32'(keying_pkg::RATE_MIN)) begin
      r = v[29:0];
    end
    return r;
  endfunction

  // Produces a bipolar sample of one modulating shape.
  function automatic logic signed [11:0] shape_val(
    input logic [2:0] sel,
    input logic [11:0] ph,
    input logic [15:0] rnd,
    input logic signed [11:0] arb
  );
    logic signed [11:0] saw;
    logic signed [11:0] tri_v;
    logic signed [23:0] par;
    logic [11:0] mag;
    logic signed [11:0] v;
    saw = signed'(ph ^ 12'h800);
    tri_v = signed'({ph[11] ? ~ph[10:0] : ph[10:0], 1'b0} ^ 12'h800);
    mag = saw[11] ? 12'(-saw) : saw;
    par = (24'(saw) * 24'(signed'(12'h800 - mag))) >>> 9;
    v = arb;
    case (sel)
      keying_pkg::SHP_SINE: begin
        if (par > 24'(keying_pkg::MOD_FULL)) begin
          v = keying_pkg::MOD_FULL;
        end else if (par < -24'(keying_pkg::MOD_FULL)) begin
          v = -keying_pkg::MOD_FULL;
        end else begin
          v = par[11:0];
        end
      end
      keying_pkg::SHP_SQUARE: begin
        v = ph[11] ? -keying_pkg::MOD_FULL : keying_pkg::MOD_FULL;
      end
      keying_pkg::SHP_TRIANGLE: begin
        v = tri_v;
      end
      keying_pkg::SHP_RISING_SAWTOOTH: begin
        v = saw;
      end
      keying_pkg::SHP_FALLING_SAWTOOTH: begin
        v = -saw;
      end
      keying_pkg::SHP_NOISE: begin
        v = signed'(rnd[11:0]);
      end
      default: begin
        v = arb;
      end
    endcase
    return v;
  endfunction

  assign ext_src = ctrl[keying_pkg::CTRL_EXT];
  assign use_rear = ctrl[keying_pkg::CTRL_REAR];
  assign mod_en = ctrl[keying_pkg::CTRL_MOD_EN];
  assign fsk_neg = ctrl[keying_pkg::CTRL_FSK_NEG];
  assign psk_neg = ctrl[keying_pkg::CTRL_PSK_NEG];
  assign by_duty = ctrl[keying_pkg::CTRL_BY_DUTY];
  assign car_shape =
    keying_pkg::carrier_t'(ctrl[keying_pkg::CTRL_SHAPE_LSB +: 3]);

  // A pulse carrier under modulation is always pulse width modulated.
  assign eff_type = (car_shape == keying_pkg::CAR_PULSE) ?
    keying_pkg::MOD_PWM :
    keying_pkg::mod_type_t'(ctrl[keying_pkg::CTRL_TYPE_LSB +: 2]); // [RQ10]

  assign psk_carrier_ok = (car_shape == keying_pkg::CAR_SINE) ||
    (car_shape == keying_pkg::CAR_SQUARE) ||
    (car_shape == keying_pkg::CAR_RAMP) ||
    (car_shape == keying_pkg::CAR_ARB); // [RQ19]

  // The keying level: accumulator MSB is a square of exact 50% duty.
  always_comb begin
    if (!ext_src) begin
      key_now = acc[0][keying_pkg::ACC_W-1]; // [RQ4]
    end else if (use_rear) begin
      key_now = rear_s2; // [RQ5]
    end else begin
      key_now = front_s2; // [RQ5]
    end
  end

  // APB handshake: one wait state, then the access completes.
  assign bus_access = psel && penable;
  assign wr_en = clk_en && bus_access && pready && pwrite;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else if (clk_en) begin
      pready <= bus_access && !pready;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (clk_en && bus_access && !pready) begin
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      if (paddr == keying_pkg::OFS_CTRL) begin
        prdata <= ctrl;
      end else if (paddr == keying_pkg::OFS_RATE[0]) begin
        prdata <= 32'(rate[0]);
      end else if (paddr == keying_pkg::OFS_RATE[1]) begin
        prdata <= 32'(rate[1]);
      end else if (paddr == keying_pkg::OFS_RATE[2]) begin
        prdata <= 32'(rate[2]);
      end else if (paddr == keying_pkg::OFS_CAR_PHASE) begin
        prdata <= 32'(car_phase);
      end else if (paddr == keying_pkg::OFS_MOD_PHASE) begin
        prdata <= 32'(mod_phase);
      end else if (paddr == keying_pkg::OFS_SHAPES) begin
        prdata <= 32'(shapes);
      end else if (paddr == keying_pkg::OFS_PWM_NOM) begin
        prdata <= pwm_nom;
      end else if (paddr == keying_pkg::OFS_PWM_DEV) begin
        prdata <= pwm_dev;
      end else if (paddr == keying_pkg::OFS_PWM_EDGE) begin
        prdata <= pwm_edge;
      end else if (paddr == keying_pkg::OFS_SUM_RATIO) begin
        prdata <= 32'(sum_ratio);
      end else if (paddr == keying_pkg::OFS_CAR_AMPL) begin
        prdata <= car_ampl;
      end else if (paddr == keying_pkg::OFS_STATUS) begin
        prdata <= {28'h000_0000, psk_carrier_ok, eff_type, key_level};
      end else begin
        pslverr <= 1'b1;
      end
    end
  end

  // Control and setting registers; out-of-range writes are clamped.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= keying_pkg::CTRL_RESET;
      car_phase <= keying_pkg::CAR_PHASE_RESET; // [RQ3]
      mod_phase <= keying_pkg::MOD_PHASE_RESET; // [RQ8]
      shapes <= 8'h00;
    end else if (wr_en) begin
      if (paddr == keying_pkg::OFS_CTRL) begin
        ctrl <= pwdata;
      end else if (paddr == keying_pkg::OFS_CAR_PHASE) begin
        if (signed'(pwdata) > keying_pkg::PHASE_LIMIT) begin
          car_phase <= 17'(keying_pkg::PHASE_LIMIT); // [RQ3]
        end else if (signed'(pwdata) < -keying_pkg::PHASE_LIMIT) begin
          car_phase <= 17'(-keying_pkg::PHASE_LIMIT); // [RQ3]
        end else begin
          car_phase <= pwdata[16:0];
        end
      end else if (paddr == keying_pkg::OFS_MOD_PHASE) begin
        if (pwdata > 32'(keying_pkg::PHASE_LIMIT)) begin
          mod_phase <= 16'(keying_pkg::PHASE_LIMIT); // [RQ8]
        end else begin
          mod_phase <= pwdata[15:0];
        end
      end else if (paddr == keying_pkg::OFS_SHAPES) begin
        shapes <= pwdata[7:0]; // [RQ11] [RQ17]
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwm_nom <= 32'h0000_0000;
      pwm_dev <= 32'h0000_0000;
      pwm_edge <= 32'h0000_0000;
      sum_ratio <= keying_pkg::RATIO_RESET; // [RQ18]
      car_ampl <= 32'h0000_0000;
    end else if (wr_en) begin
      if (paddr == keying_pkg::OFS_PWM_NOM) begin
        pwm_nom <= pwdata;
      end else if (paddr == keying_pkg::OFS_PWM_DEV) begin
        pwm_dev <= pwdata;
      end else if (paddr == keying_pkg::OFS_PWM_EDGE) begin
        pwm_edge <= pwdata;
      end else if (paddr == keying_pkg::OFS_SUM_RATIO) begin
        if (pwdata > 32'(keying_pkg::RATIO_MAX)) begin
          sum_ratio <= keying_pkg::RATIO_MAX; // [RQ18]
        end else begin
          sum_ratio <= pwdata[6:0];
        end
      end else if (paddr == keying_pkg::OFS_CAR_AMPL) begin
        car_ampl <= pwdata;
      end
    end
  end

  // Front and rear keying pins are asynchronous to pclk.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      front_s1 <= 1'b0;
      front_s2 <= 1'b0;
      rear_s1 <= 1'b0;
      rear_s2 <= 1'b0;
    end else if (clk_en) begin
      front_s1 <= front_key_in;
      front_s2 <= front_s1;
      rear_s1 <= rear_key_in;
      rear_s2 <= rear_s1;
    end
  end

  // Accumulator 0 keys, 1 shapes the pulse width, 2 makes the added wave.
  // An external source stalls the keying and PWM accumulators.
  assign acc_run[0] = mod_en && !ext_src &&
    ((eff_type == keying_pkg::MOD_FSK) ||
     (eff_type == keying_pkg::MOD_PSK)); // [RQ7]
  assign acc_run[1] = mod_en && !ext_src &&
    (eff_type == keying_pkg::MOD_PWM); // [RQ12]
  assign acc_run[2] = mod_en && (eff_type == keying_pkg::MOD_SUM);

  generate
    for (genvar i = 0; i < 3; i++) begin : gen_gen
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          rate[i] <= keying_pkg::RATE_RESET; // [RQ6] [RQ13]
        end else if (wr_en && paddr == keying_pkg::OFS_RATE[i]) begin
          rate[i] <= clamp_rate(pwdata); // [RQ6] [RQ13] [RQ17]
        end
      end

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          acc[i] <= '0;
        end else if (clk_en && acc_run[i]) begin
          acc[i] <= acc[i] + keying_pkg::ACC_W'(rate[i]) *
            keying_pkg::ACC_W'(keying_pkg::INC_SCALE);
        end
      end
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lfsr <= keying_pkg::LFSR_SEED;
    end else if (clk_en) begin
      lfsr <= (lfsr >> 1) ^ (lfsr[0] ? keying_pkg::LFSR_TAPS : 16'h0000);
    end
  end

  // PWM deviation limits, in time or duty units as the carrier is set.
  always_comb begin
    nom_less_edge = (pwm_nom > pwm_edge) ? pwm_nom - pwm_edge : '0;
    full_less = (keying_pkg::DUTY_FULL > pwm_nom + pwm_edge) ?
      keying_pkg::DUTY_FULL - pwm_nom - pwm_edge : '0;
    dev_lim = nom_less_edge; // [RQ15]
    if (by_duty) begin
      if (full_less < dev_lim) begin
        dev_lim = full_less; // [RQ14]
      end
      if (keying_pkg::DUTY_DEV_MAX < dev_lim) begin
        dev_lim = keying_pkg::DUTY_DEV_MAX; // [RQ16]
      end
    end
    dev_eff = (pwm_dev < dev_lim) ? pwm_dev : dev_lim;
  end

  assign pwm_mod = ext_src ? front_level :
    shape_val(shapes[2:0], acc[1][keying_pkg::ACC_W-1 -: 12], lfsr,
              arb_sample); // [RQ11] [RQ12]
  assign sum_mod = shape_val(shapes[keying_pkg::SHAPES_SUM_LSB +: 3],
    acc[2][keying_pkg::ACC_W-1 -: 12], lfsr, arb_sample); // [RQ17]

  // Full scale of the modulating value gives the full deviation.
  // Dividing by full scale, not by a power of two, keeps the peak exact.
  assign dev_prod = (45'(signed'({1'b0, dev_eff})) * 45'(pwm_mod)) /
    45'(keying_pkg::MOD_FULL); // [RQ12]
  assign width_sum = 34'(signed'({1'b0, pwm_nom})) + dev_prod[33:0];
  assign ampl_prod = 40'(car_ampl) *
    40'(keying_pkg::PCT_FULL + 8'(sum_ratio)); // [RQ18]

  // Results, registered so a switch lands on the next sample only.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      key_level <= 1'b0;
      freq_alt <= 1'b0;
      phase_out <= keying_pkg::CAR_PHASE_RESET;
    end else if (clk_en) begin
      key_level <= key_now;
      freq_alt <= 1'b0;
      phase_out <= car_phase; // [RQ20]
      if (mod_en && psk_carrier_ok) begin
        if (eff_type == keying_pkg::MOD_FSK) begin
          freq_alt <= key_now ^ fsk_neg; // [RQ1] [RQ2]
        end else if (eff_type == keying_pkg::MOD_PSK &&
                     (key_now ^ psk_neg)) begin
          phase_out <= signed'({1'b0, mod_phase}); // [RQ9]
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwm_width <= 32'h0000_0000;
      sum_ampl <= 40'h00_0000_0000;
      sum_wave <= 12'sh000;
    end else if (clk_en) begin
      pwm_width <= pwm_nom;
      if (acc_run[1] || (mod_en && ext_src &&
          eff_type == keying_pkg::MOD_PWM)) begin
        pwm_width <= width_sum[33] ? 32'h0000_0000 :
          width_sum[31:0]; // [RQ15]
      end
      sum_wave <= acc_run[2] ? sum_mod : 12'sh000;
      // The peak cap keeps the summed output inside the amplifier range.
      sum_ampl <= (ampl_prod > keying_pkg::MAX_PEAK * 40'(
        keying_pkg::PCT_FULL)) ? keying_pkg::MAX_PEAK * 40'(
        keying_pkg::PCT_FULL) : ampl_prod; // [RQ18]
    end
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence key_rise_s;
    !key_now ##1 key_now;
  endsequence

  fsk_positive_a: assert property (clk_en && mod_en && psk_carrier_ok &&
    eff_type == keying_pkg::MOD_FSK && !fsk_neg |=>
    freq_alt == $past(key_now)) else $error("fsk positive wrong"); // [RQ1]
  fsk_negative_a: assert property (clk_en && mod_en && psk_carrier_ok &&
    eff_type == keying_pkg::MOD_FSK && fsk_neg |=>
    freq_alt != $past(key_now)) else $error("fsk negative wrong"); // [RQ2]
  car_phase_range_a: assert property (car_phase <= 17'sd36000 &&
    car_phase >= -17'sd36000) else $error("carrier phase range"); // [RQ3]
  int_square_a: assert property (!ext_src && clk_en |=>
    key_level == $past(acc[0][keying_pkg::ACC_W-1]))
    else $error("internal key wrong"); // [RQ4]
  port_select_a: assert property (ext_src && use_rear && clk_en |=>
    key_level == $past(rear_s2)) else $error("rear port wrong"); // [RQ5]
  key_rate_range_a: assert property (rate[0] >= keying_pkg::RATE_MIN &&
    rate[0] <= keying_pkg::RATE_MAX) else $error("key rate range"); // [RQ6]
  ext_freeze_a: assert property (clk_en && ext_src |=> $stable(acc[0]))
    else $error("accumulator ran"); // [RQ7]
  mod_phase_range_a: assert property (mod_phase <= 16'd36000)
    else $error("modulation phase range"); // [RQ8]
  psk_edge_a: assert property (clk_en && mod_en && psk_carrier_ok &&
    eff_type == keying_pkg::MOD_PSK && !psk_neg && !ctrl_wr_any()
    ##0 key_rise_s ##0 clk_en |=> phase_out == signed'({1'b0, mod_phase}))
    else $error("psk phase wrong"); // [RQ9]
  pwm_force_a: assert property (car_shape == keying_pkg::CAR_PULSE |->
    eff_type == keying_pkg::MOD_PWM) else $error("pwm not forced"); // [RQ10]
  duty_cap_a: assert property (by_duty |-> dev_eff <= 32'd4999)
    else $error("duty deviation cap"); // [RQ16]
  sum_ratio_a: assert property (sum_ratio <= 7'd100 &&
    sum_ampl <= 40'd1000000) else $error("sum amplitude cap"); // [RQ18]

  function automatic logic ctrl_wr_any();
    return wr_en;
  endfunction

endmodule

// >>> test/key_source.sv
// Behavioural model of the front and rear modulation sources.
`timescale 1ns/100ps

module key_source (
  // Clock.
  input wire logic pclk,
  // Source outputs.
  output logic front_key_in,
  output logic rear_key_in,
  output logic signed [11:0] front_level,
  output logic signed [11:0] arb_sample
);
  // Half periods at 100 kHz front and 10 MHz rear, so no edge comes faster.
  localparam int FRONT_HOLD = 625;
  localparam int REAR_HOLD = 7;
  int cyc = 0;
  int last_front = 0;
  int last_rear = 0;
  initial begin
    front_key_in = 1'b0;
    rear_key_in = 1'b0;
    front_level = 12'sh000;
    arb_sample = 12'sh000;
  end
  // The shape sample never sits still, so a stale value cannot hide.
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    arb_sample <= arb_sample + 12'sh0d3;
  end
  task automatic set_key(input logic rear, input logic v);
    @(posedge pclk);
    while (rear && cyc - last_rear < REAR_HOLD) @(posedge pclk);
    while (!rear && cyc - last_front < FRONT_HOLD) @(posedge pclk);
    if (rear) begin
      rear_key_in <= v;
      last_rear = cyc;
    end else begin
      front_key_in <= v;
      last_front = cyc;
    end
  endtask
  // Full scale of 2047 stands for the 5 V input limit.
  task automatic set_level(input logic signed [11:0] v);
    @(posedge pclk);
    front_level <= v;
  endtask
endmodule

// >>> test/tb_top.sv
// Self-checking bench for the keying, pulse and summing modulator.
`timescale 1ns/100ps

module tb_top;
  logic pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, pwm_width, rd;
  logic front_key_in, rear_key_in, freq_alt, key_level, er;
  logic signed [11:0] front_level, arb_sample, sum_wave;
  logic signed [16:0] phase_out;
  logic [39:0] sum_ampl;
  int err_count = 0;
  int num_checks = 0;
  int cyc = 0;
  int hi = 0;

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  keying_pulse_sum_modulator i_dut (.pclk(pclk), .presetn(presetn),
    .clk_en(clk_en), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .front_key_in(front_key_in),
    .rear_key_in(rear_key_in), .front_level(front_level),
    .arb_sample(arb_sample), .freq_alt(freq_alt), .phase_out(phase_out),
    .pwm_width(pwm_width), .sum_ampl(sum_ampl), .sum_wave(sum_wave),
    .key_level(key_level));

  key_source i_src (.pclk(pclk), .front_key_in(front_key_in),
    .rear_key_in(rear_key_in), .front_level(front_level),
    .arb_sample(arb_sample));

  task automatic close_out;
    if (err_count == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t got %0h expected %0h", $time, got, exp);
    end
  endtask

  // The request stands until pready is seen high at a rising edge.
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd, exp);
  endtask

  // Outputs lag the key by three edges; eight leaves margin for all paths.
  task automatic settle;
    repeat (8) @(posedge pclk);
  endtask

  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      err_count++;
      close_out();
    end
  end

  initial begin
    presetn = 1'b0;
    clk_en = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rdc(keying_pkg::OFS_CTRL, 32'h0000_0000);
    for (int i = 0; i < 3; i++) begin
      rdc(keying_pkg::OFS_RATE[i], 32'h0001_86a0);
    end
    rdc(keying_pkg::OFS_CAR_PHASE, 32'h0000_0000);
    rdc(keying_pkg::OFS_MOD_PHASE, 32'h0000_4650);
    rdc(keying_pkg::OFS_SUM_RATIO, 32'h0000_0032);
    apb(1'b0, 8'h3c, 32'h0000_0000);
    chk(er, 1'b1);
    wr(keying_pkg::OFS_MOD_PHASE, 32'h0000_9c40);
    rdc(keying_pkg::OFS_MOD_PHASE, 32'h0000_8ca0);
    wr(keying_pkg::OFS_RATE[0], 32'h0000_0000);
    rdc(keying_pkg::OFS_RATE[0], 32'h0000_0002);
    wr(keying_pkg::OFS_RATE[1], 32'h7735_9400);
    rdc(keying_pkg::OFS_RATE[1], 32'h3b9a_ca00);
    // Frequency keying from the front pin, both polarities, then from the rear pin.
    wr(keying_pkg::OFS_CTRL, 32'h0000_0018);
    i_src.set_key(1'b0, 1'b1);
    settle();
    chk(freq_alt, 1'b1);
    chk(sum_wave, 12'sh000);
    wr(keying_pkg::OFS_CTRL, 32'h0000_0058);
    settle();
    chk(freq_alt, 1'b0);
    i_src.set_key(1'b0, 1'b0);
    settle();
    chk(freq_alt, 1'b1);
    wr(keying_pkg::OFS_CTRL, 32'h0000_0038);
    i_src.set_key(1'b1, 1'b1);
    settle();
    chk(freq_alt, 1'b1);
    i_src.set_key(1'b1, 1'b0);
    settle();
    chk(freq_alt, 1'b0);
    // Phase keying from the front pin.
    wr(keying_pkg::OFS_CAR_PHASE, 32'hffff_dcd8);
    wr(keying_pkg::OFS_MOD_PHASE, 32'h0000_1194);
    wr(keying_pkg::OFS_CTRL, 32'h0000_0019);
    settle();
    chk(phase_out, -17'sd9000);
    i_src.set_key(1'b0, 1'b1);
    settle();
    chk(phase_out, 17'sd4500);
    wr(keying_pkg::OFS_CTRL, 32'h0000_0099);
    wr(keying_pkg::OFS_CAR_PHASE, 32'hffff_63c0);
    settle();
    chk(phase_out, -17'sd36000);
    wr(keying_pkg::OFS_RATE[0], 32'h3b9a_ca00);
    repeat (8) begin
      repeat (20) @(posedge pclk);
      chk(key_level, 1'b1);
    end
    // Internal square at 1 MHz: 625 high cycles in ten periods.
    wr(keying_pkg::OFS_CTRL, 32'h0000_0009);
    repeat (1250) begin
      @(posedge pclk);
      hi += int'(key_level === 1'b1);
    end
    chk(hi >= 600 && hi <= 650, 1'b1);
    wr(keying_pkg::OFS_CTRL, 32'h0000_3008);
    apb(1'b0, keying_pkg::OFS_STATUS, 32'h0000_0000);
    chk(rd[2:1], 2'b10);
    wr(keying_pkg::OFS_CTRL, 32'h0000_6009);
    apb(1'b0, keying_pkg::OFS_STATUS, 32'h0000_0000);
    chk(rd[3], 1'b0);
    wr(keying_pkg::OFS_CTRL, 32'h0000_5009);
    apb(1'b0, keying_pkg::OFS_STATUS, 32'h0000_0000);
    chk(rd[3], 1'b1);
    // Width modulation from the front level.
    wr(keying_pkg::OFS_CTRL, 32'h0000_301a);
    wr(keying_pkg::OFS_PWM_NOM, 32'd1000);
    wr(keying_pkg::OFS_PWM_DEV, 32'd100);
    wr(keying_pkg::OFS_PWM_EDGE, 32'd10);
    i_src.set_level(12'sd2047);
    settle();
    chk(pwm_width, 32'd1100);
    i_src.set_level(-12'sd2047);
    settle();
    chk(pwm_width, 32'd900);
    wr(keying_pkg::OFS_PWM_DEV, 32'd2000);
    i_src.set_level(12'sd2047);
    settle();
    chk(pwm_width, 32'd1990);
    wr(keying_pkg::OFS_CTRL, 32'h0000_311a);
    wr(keying_pkg::OFS_PWM_NOM, 32'd5000);
    wr(keying_pkg::OFS_PWM_DEV, 32'd6000);
    wr(keying_pkg::OFS_PWM_EDGE, 32'd0);
    settle();
    chk(pwm_width, 32'd9999);
    // Summing amplitude and its ceiling.
    wr(keying_pkg::OFS_CTRL, 32'h0000_000b);
    wr(keying_pkg::OFS_CAR_AMPL, 32'd1000);
    settle();
    chk(sum_ampl, 40'd150000);
    wr(keying_pkg::OFS_SUM_RATIO, 32'd200);
    rdc(keying_pkg::OFS_SUM_RATIO, 32'd100);
    settle();
    chk(sum_ampl, 40'd200000);
    wr(keying_pkg::OFS_CAR_AMPL, 32'd20000);
    settle();
    chk(sum_ampl, 40'd1000000);
    close_out();
  end
endmodule
